/* phy_mii_data_interface.sv */
// phy side mii data path: receive framing toward the mac, transmit sampling
// assumes pcs strobes arrive on ref_clk; mac pins and tristate pin are asynchronous
`timescale 1ns/10ps
`include "mii_phy_map.svh"

module phy_mii_data_interface (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// mode
	input wire logic speed_100,
	input wire logic link_up,
	// pcs receive side
	input wire mii_phy_pkg::nibble_type pcs_rx_nib,
	input wire logic pcs_rx_nib_valid,
	input wire logic pcs_rx_sof,
	input wire logic pcs_rx_eof,
	input wire logic pcs_rx_sig_err,
	input wire logic pcs_rx_code_err,
	input wire logic pcs_false_carrier,
	// mii receive pins
	output logic rx_clk,
	output mii_phy_pkg::nibble_type rxd,
	output logic rx_dv,
	output logic rx_er,
	output logic rx_er_oe,
	input wire logic receive_tristate_control,
	// mii transmit pins
	output logic tx_clk,
	input wire mii_phy_pkg::nibble_type txd,
	input wire logic tx_en,
	// media transmit side
	output mii_phy_pkg::nibble_type media_tx_nib,
	output logic media_tx_valid,
	output logic media_tx_active
);
	import mii_phy_pkg::*;

	// ----------------------------------------------------------------
	// clock dividers
	// ----------------------------------------------------------------
	function automatic logic [5:0] half_last(input logic fast);
		half_last = fast ? 6'((`HALF_100_CYC) - 1) : 6'((`HALF_10_CYC) - 1);
	endfunction : half_last

	logic [5:0] tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d;
	logic tx_clk_q, tx_clk_d, rx_clk_q, rx_clk_d;
	logic link_q;
	logic link_rise, tx_rise, rx_fall, tx_wrap, rx_wrap;

	assign link_rise = link_up && !link_q;
	assign tx_wrap = tx_cnt_q >= half_last(speed_100);
	assign rx_wrap = rx_cnt_q >= half_last(speed_100);
	assign tx_rise = tx_wrap && !tx_clk_q;
	assign rx_fall = rx_wrap && rx_clk_q && !link_rise;

	always_comb begin
		tx_cnt_d = tx_cnt_q + 6'h01;
		tx_clk_d = tx_clk_q;
		if (tx_wrap) begin
			tx_cnt_d = `CNT_RST;
			tx_clk_d = !tx_clk_q;
		end
		rx_cnt_d = rx_cnt_q + 6'h01;
		rx_clk_d = rx_clk_q;
		if (link_rise) begin
			rx_cnt_d = `CNT_RST;
			rx_clk_d = 1'b0;
		end else if (rx_wrap) begin
			rx_cnt_d = `CNT_RST;
			rx_clk_d = !rx_clk_q;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tx_cnt_q <= `CNT_RST;
			rx_cnt_q <= `CNT_RST;
			tx_clk_q <= 1'b0;
			rx_clk_q <= 1'b0;
			link_q <= 1'b0;
		end else begin
			tx_cnt_q <= tx_cnt_d;
			rx_cnt_q <= rx_cnt_d;
			tx_clk_q <= tx_clk_d;
			rx_clk_q <= rx_clk_d;
			link_q <= link_up;
		end
	end

	assign tx_clk = tx_clk_q;
	assign rx_clk = rx_clk_q;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	nibble_type txd_s1, txd_s2;
	logic txen_s1, txen_s2, tri_s1, tri_s2;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			txd_s1 <= `NIB_RST;
			txd_s2 <= `NIB_RST;
			txen_s1 <= 1'b0;
			txen_s2 <= 1'b0;
			tri_s1 <= 1'b0;
			tri_s2 <= 1'b0;
		end else begin
			txd_s1 <= txd;
			txd_s2 <= txd_s1;
			txen_s1 <= tx_en;
			txen_s2 <= txen_s1;
			tri_s1 <= receive_tristate_control;
			tri_s2 <= tri_s1;
		end
	end

	assign rx_er_oe = !tri_s2;

	// ----------------------------------------------------------------
	// receive framing
	// ----------------------------------------------------------------
	rx_state_type st_q, st_d;
	nibble_type hold_q, hold_d, rxd_q, rxd_d;
	logic dv_q, dv_d, er_q, er_d, pend_q, pend_d, err_now;

	assign err_now = (st_q == rx_frame && pcs_rx_code_err) ||
		(st_q == rx_idle && pcs_false_carrier);

	always_comb begin
		st_d = st_q;
		hold_d = pcs_rx_nib_valid ? pcs_rx_nib : hold_q;
		pend_d = pend_q;
		rxd_d = rxd_q;
		dv_d = dv_q;
		er_d = er_q;
		unique case (st_q)
			rx_idle: begin
				if (pcs_rx_sof) begin
					st_d = rx_frame;
				end
			end
			rx_frame: begin
				if (pcs_rx_eof || pcs_rx_sig_err) begin
					st_d = rx_idle;
				end
			end
			default: begin
				st_d = rx_idle;
			end
		endcase
		if (rx_fall) begin
			rxd_d = hold_q;
			dv_d = (st_q == rx_frame);
			er_d = speed_100 && (pend_q || err_now);
			pend_d = 1'b0;
		end
		if (err_now) begin
			pend_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_q <= rx_idle;
			hold_q <= `NIB_RST;
			pend_q <= 1'b0;
			rxd_q <= `NIB_RST;
			dv_q <= 1'b0;
			er_q <= 1'b0;
		end else begin
			st_q <= st_d;
			hold_q <= hold_d;
			pend_q <= pend_d;
			rxd_q <= rxd_d;
			dv_q <= dv_d;
			er_q <= er_d;
		end
	end

	assign rxd = rxd_q;
	assign rx_dv = dv_q;
	assign rx_er = er_q;

	// ----------------------------------------------------------------
	// transmit sampling
	// ----------------------------------------------------------------
	nibble_type tnib_q, tnib_d;
	logic tval_q, tval_d, tact_q, tact_d;

	always_comb begin
		tnib_d = tnib_q;
		tval_d = 1'b0;
		tact_d = tact_q;
		if (tx_rise) begin
			tact_d = txen_s2;
			if (txen_s2) begin
				tnib_d = txd_s2;
				tval_d = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tnib_q <= `NIB_RST;
			tval_q <= 1'b0;
			tact_q <= 1'b0;
		end else begin
			tnib_q <= tnib_d;
			tval_q <= tval_d;
			tact_q <= tact_d;
		end
	end

	assign media_tx_nib = tnib_q;
	assign media_tx_valid = tval_q;
	assign media_tx_active = tact_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence fast_rise(logic c, logic q);
		($rose(c) && !q && speed_100 && $past(speed_100)) ##1 (speed_100 && !q) [*4];
	endsequence

	chk_dv_clock_step: assert property (@(posedge ref_clk) disable iff (rst)
		$changed(rx_dv) |-> $past(rx_fall)) else $error("rx_dv moved off rx clock fall");
	chk_er_clock_step: assert property (@(posedge ref_clk) disable iff (rst)
		$changed(rx_er) |-> $past(rx_fall)) else $error("rx_er moved off rx clock fall");
	chk_er_10m_quiet: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(rx_er) |-> $past(speed_100)) else $error("rx_er raised in 10M mode");
	chk_dv_after_sof: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(rx_dv) |-> $past(st_q == rx_frame)) else $error("rx_dv without start delimiter");
	chk_dv_end_frame: assert property (@(posedge ref_clk) disable iff (rst)
		(rx_fall && st_q == rx_idle) |=> !rx_dv) else $error("rx_dv held after frame end");
	chk_rxd_from_hold: assert property (@(posedge ref_clk) disable iff (rst)
		rx_fall |=> rxd == $past(hold_q)) else $error("rxd not loaded at rx clock fall");
	chk_er_gate_pin: assert property (@(posedge ref_clk) disable iff (rst)
		receive_tristate_control ##1 receive_tristate_control |=> !rx_er_oe)
		else $error("rx_er driven while tristated");
	chk_txclk_fast_high: assert property (@(posedge ref_clk) disable iff (rst)
		fast_rise(tx_clk, 1'b0) |-> (!tx_clk && $past(tx_clk) && $past(tx_clk, 2) &&
		$past(tx_clk, 3))) else $error("tx clock high time wrong at 100M");
	chk_rxclk_fast_high: assert property (@(posedge ref_clk) disable iff (rst)
		fast_rise(rx_clk, link_rise) |-> (!rx_clk && $past(rx_clk) && $past(rx_clk, 2) &&
		$past(rx_clk, 3))) else $error("rx clock high time wrong at 100M");
	chk_rx_realign_link: assert property (@(posedge ref_clk) disable iff (rst)
		link_rise |=> (rx_cnt_q == `CNT_RST && !rx_clk)) else $error("rx clock not realigned");
	chk_tx_sample_nib: assert property (@(posedge ref_clk) disable iff (rst)
		(tx_rise && txen_s2) |=> (media_tx_valid && media_tx_nib == $past(txd_s2)))
		else $error("transmit nibble not sampled");
	chk_tx_stop_media: assert property (@(posedge ref_clk) disable iff (rst)
		(tx_rise && !txen_s2) |=> (!media_tx_valid && !media_tx_active) [*2])
		else $error("media transmit continued after enable dropped");

endmodule : phy_mii_data_interface

/* mii_phy_map.svh */
// timing constants and reset values for the phy side mii data path
// assumes a single reference clock feeding all logic of the block
`ifndef MII_PHY_MAP_SVH
`define MII_PHY_MAP_SVH

// ----------------------------------------------------------------
// clock rates in khz
// ----------------------------------------------------------------
`define REF_CLK_KHZ 200000
`define MII_CLK_100_KHZ 25000
`define MII_CLK_10_KHZ 2500

// ----------------------------------------------------------------
// derived half periods in reference cycles
// ----------------------------------------------------------------
`define HALF_100_CYC (`REF_CLK_KHZ / (2 * `MII_CLK_100_KHZ))
`define HALF_10_CYC (`REF_CLK_KHZ / (2 * `MII_CLK_10_KHZ))

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define NIB_RST 4'h0
`define CNT_RST 6'h00

`endif

/* mii_phy_pkg.sv */
// types shared by the phy side mii data path
// assumes the map header supplies all numeric constants
package mii_phy_pkg;

	// ----------------------------------------------------------------
	// receive framing state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		rx_idle = 2'b01,
		rx_frame = 2'b10
	} rx_state_type;

	typedef logic [3:0] nibble_type;

endpackage : mii_phy_pkg

/* mac_model.sv */
// behavioural mac on the mii pins of the phy data path
// assumes tx_clk and rx_clk are sourced by the phy, go and nibble by the bench
`timescale 1ns/10ps
module mac_model (
	// mii pins
	input wire logic rx_clk,
	input wire mii_phy_pkg::nibble_type rxd,
	input wire logic rx_dv,
	input wire logic tx_clk,
	output mii_phy_pkg::nibble_type txd,
	output logic tx_en,
	// bench side
	input wire logic send_go,
	input wire mii_phy_pkg::nibble_type send_nib,
	output mii_phy_pkg::nibble_type cap_nib
);
	import mii_phy_pkg::*;
	initial begin
		txd = 4'h0;
		tx_en = 1'h0;
		cap_nib = 4'h0;
	end
	// launch just after tx_clk rises, idle lines toggle
	always @(posedge tx_clk) begin
		#1;
		tx_en = send_go;
		txd = send_go ? send_nib : ~txd;
	end
	// capture valid nibbles only
	always @(posedge rx_clk) begin
		if (rx_dv === 1'h1) begin
			cap_nib = rxd;
		end
	end
endmodule : mac_model

/* testbench.sv */
// self-checking bench for the phy side mii data path
// assumes mac_model on the mii pins, bench drives pcs strobes
`timescale 1ns/10ps
`include "mii_phy_map.svh"
module testbench;
	import mii_phy_pkg::*;
	logic ref_clk = 1'h0;
	logic rst = 1'h1;
	logic speed_100 = 1'h1;
	logic link_up = 1'h1;
	logic trc = 1'h0;
	logic go = 1'h0;
	logic [5:0] st = 6'h00;
	nibble_type nib = 4'h0;
	nibble_type snib = 4'h0;
	logic rx_clk, rx_dv, rx_er, rx_er_oe, tx_clk, tx_en, mtv, mta;
	nibble_type rxd, txd, mtn, cap;
	int error_cnt = 0;
	int n_compared = 0;
	int cyc = 0;
	int vcnt = 0;
	localparam int p100 = 1000000 / `MII_CLK_100_KHZ;
	localparam int p10 = 1000000 / `MII_CLK_10_KHZ;

	phy_mii_data_interface dut (.ref_clk(ref_clk), .rst(rst), .speed_100(speed_100),
		.link_up(link_up), .pcs_rx_nib(nib), .pcs_rx_nib_valid(st[5]),
		.pcs_rx_sof(st[0]), .pcs_rx_eof(st[1]), .pcs_rx_sig_err(st[2]),
		.pcs_rx_code_err(st[3]), .pcs_false_carrier(st[4]), .rx_clk(rx_clk),
		.rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .rx_er_oe(rx_er_oe),
		.receive_tristate_control(trc), .tx_clk(tx_clk), .txd(txd), .tx_en(tx_en),
		.media_tx_nib(mtn), .media_tx_valid(mtv), .media_tx_active(mta));
	mac_model mac (.rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv), .tx_clk(tx_clk), .txd(txd),
		.tx_en(tx_en), .send_go(go), .send_nib(snib), .cap_nib(cap));

	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (mtv === 1'h1) begin
			vcnt++;
		end
		if (cyc == 10000) begin
			error_cnt++;
			wrap_up;
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic strobe(input int k);
		@(negedge ref_clk);
		st = 6'h01 << k;
		@(negedge ref_clk);
		st = 6'h00;
	endtask : strobe
	task automatic fall(input int n);
		repeat (n) @(negedge rx_clk);
		@(negedge ref_clk);
	endtask : fall
	task automatic period(input int exp);
		realtime t0;
		@(posedge rx_clk);
		t0 = $realtime;
		@(posedge rx_clk);
		chk(16'(int'($realtime - t0)), 16'(exp));
		@(posedge tx_clk);
		t0 = $realtime;
		@(posedge tx_clk);
		chk(16'(int'($realtime - t0)), 16'(exp));
		@(negedge ref_clk);
	endtask : period
	task automatic wait_v;
		int i;
		i = 0;
		do begin
			@(negedge ref_clk);
			i++;
		end while (mtv !== 1'h1 && i < 40);
	endtask : wait_v
	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : wrap_up

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_clk;
		link_up = 1'h0;
		@(negedge ref_clk);
		link_up = 1'h1;
		repeat (2) @(negedge ref_clk);
		chk(rx_clk, 1'h0);
		repeat (2) @(negedge ref_clk);
		chk(rx_clk, 1'h0);
		@(negedge ref_clk);
		chk(rx_clk, 1'h1);
		period(p100);
	endtask : t_clk
	task automatic t_frame;
		nib = 4'h3;
		strobe(5);
		fall(2);
		chk(rx_dv, 1'h0);
		strobe(0);
		nib = 4'ha;
		strobe(5);
		fall(2);
		chk(rx_dv, 1'h1);
		chk(rxd, 4'ha);
		@(posedge rx_clk);
		#1;
		chk(cap, 4'ha);
		strobe(1);
		fall(2);
		chk(rx_dv, 1'h0);
	endtask : t_frame
	task automatic t_err;
		strobe(0);
		fall(1);
		strobe(3);
		fall(1);
		chk(rx_er, 1'h1);
		fall(1);
		chk(rx_er, 1'h0);
		strobe(4);
		fall(1);
		chk(rx_er, 1'h0);
		strobe(2);
		fall(2);
		chk(rx_dv, 1'h0);
		strobe(3);
		fall(1);
		chk(rx_er, 1'h0);
		strobe(4);
		fall(1);
		chk(rx_er, 1'h1);
		fall(1);
	endtask : t_err
	task automatic t_10m;
		speed_100 = 1'h0;
		fall(1);
		period(p10);
		strobe(4);
		fall(1);
		chk(rx_er, 1'h0);
		strobe(0);
		fall(1);
		strobe(3);
		fall(1);
		chk(rx_er, 1'h0);
		chk(rx_dv, 1'h1);
		strobe(1);
		fall(2);
		speed_100 = 1'h1;
		fall(1);
	endtask : t_10m
	task automatic t_tri;
		trc = 1'h1;
		repeat (4) @(negedge ref_clk);
		chk(rx_er_oe, 1'h0);
		trc = 1'h0;
		repeat (4) @(negedge ref_clk);
		chk(rx_er_oe, 1'h1);
	endtask : t_tri
	task automatic t_tx;
		int v;
		snib = 4'h5;
		go = 1'h1;
		wait_v;
		chk(mtn, 4'h5);
		chk(mta, 1'h1);
		snib = 4'hc;
		wait_v;
		wait_v;
		chk(mtn, 4'hc);
		go = 1'h0;
		repeat (3) @(posedge tx_clk);
		@(negedge ref_clk);
		v = vcnt;
		repeat (2) @(posedge tx_clk);
		@(negedge ref_clk);
		chk(16'(vcnt - v), 16'h0);
		chk(mta, 1'h0);
	endtask : t_tx

	initial begin
		repeat (2) @(negedge ref_clk);
		rst = 1'h0;
		repeat (4) @(negedge ref_clk);
		t_clk;
		t_frame;
		t_err;
		t_10m;
		t_tri;
		t_tx;
		wrap_up;
	end
endmodule : testbench
